// *** design/mtw_top.sv ***
// How it works
// - three straps weighted four, two, one
// - channel count equals strap code plus one
// - active channels contiguous from channel one
// - inactive channels skipped in round robin
// - fourth strap selects Fahrenheit over Celsius
// - counts strap makes unit strap ignored
// - fifth strap selects counts, zero to 4094
// - millivolt builds output raw counts only
// - millivolt spans 50, 100, 25 mV
// - default eight channels, Celsius, temperature
// - one channel per scan, wrap after last
// - latest asynchronous conversion shown per scan
// - output is one sixteen bit word
// - bits 12-14 carry channel minus one
// - top bit set for negative reading
// - bits 0-11 plain binary data
// - millivolt span maps to 0..4095 codes
// - temperature in whole degrees directly
`timescale 1ns/10ps
module mtw_top
    import mtw_pkg::*;
(
    input  wire logic               clk_i,        // 125 MHz clock
    input  wire logic               srst_i,       // Sync reset
    input  wire logic               scan_i,       // Host scan pin
    input  wire logic [4:0]         strap_i,      // Jumper pins
    input  wire logic               mv_variant_i, // Millivolt build pin
    input  wire logic [1:0]         span_code_i,  // Millivolt span pin
    input  wire logic               conv_vld_i,   // Conversion done
    input  wire logic [2:0]         conv_ch_i,    // Converted index
    input  wire logic [11:0]        conv_cnt_i,   // Raw count
    input  wire logic signed [12:0] conv_temp_i,  // Degrees C
    input  wire logic [3:0]         addr_i,       // Register address
    input  wire logic [31:0]        wdata_i,      // Write data
    input  wire logic               wr_i,         // Write strobe
    input  wire logic               rd_i,         // Read strobe
    output logic      [31:0]        rdata_o,      // Read data
    output logic      [15:0]        word_o,       // Input word to host
    output logic      [2:0]         conv_sel_o    // Converter channel
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic        [2:0]  last_idx;
    logic               fahr;
    logic               counts;
    logic               mv;
    logic        [7:0]  span_mv;
    logic               scan_ff1;
    logic               scan_ff2;
    logic               scan_ff3;
    logic               scan_evt;
    logic        [2:0]  cur;
    logic        [2:0]  next_cur;
    logic        [2:0]  shown;
    logic        [2:0]  conv_ptr;
    logic               run;
    logic        [11:0] cnt_mem  [NUM_CH];
    logic signed [12:0] temp_mem [NUM_CH];
    logic        [11:0] sel_cnt;
    logic signed [12:0] sel_temp;
    logic        [11:0] fmt_data;
    logic               fmt_neg;
    logic               wr_ctrl;
    logic               restart;
    logic               advance;
    logic        [31:0] stat_word;
    logic        [31:0] rd_mux;

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    mtw_strap u_strap (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .strap_i      (strap_i),
        .mv_variant_i (mv_variant_i),
        .span_code_i  (span_code_i),
        .last_idx_o   (last_idx),
        .fahr_o       (fahr),
        .counts_o     (counts),
        .mv_o         (mv),
        .span_mv_o    (span_mv)
    );

    // ------------------------------------------------------------
    // Host scan pin
    // ------------------------------------------------------------
    // Two stages for the asynchronous pin, a third for the edge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            scan_ff1 <= 1'h0;
            scan_ff2 <= 1'h0;
            scan_ff3 <= 1'h0;
        end else begin
            scan_ff1 <= scan_i;
            scan_ff2 <= scan_ff1;
            scan_ff3 <= scan_ff2;
        end
    end

    // Rising edge of the scan is the host update instant
    assign scan_evt = scan_ff2 & ~scan_ff3;

    // ------------------------------------------------------------
    // Conversion store
    // ------------------------------------------------------------
    // The converter walks only active channels, free of the scan
    // skip inactive inputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conv_ptr <= 3'h0;
        end else if (conv_vld_i) begin
            conv_ptr <= (conv_ptr >= last_idx) ? 3'h0 : conv_ptr + 3'h1;
        end
    end

    assign conv_sel_o = conv_ptr;

    // One slot per channel; a scan reads the newest result stored before its cycle
    // latest conversion kept
    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_slot
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    cnt_mem[i]  <= 12'h000;
                    temp_mem[i] <= 13'sh0000;
                end else if (conv_vld_i && conv_ch_i == 3'(i)) begin
                    cnt_mem[i]  <= conv_cnt_i;
                    temp_mem[i] <= conv_temp_i;
                end
            end
        end
    endgenerate

    assign sel_cnt  = cnt_mem[shown];
    assign sel_temp = temp_mem[shown];

    // ------------------------------------------------------------
    // Data formatting
    // ------------------------------------------------------------
    mtw_fmt u_fmt (
        .count_i  (sel_cnt),
        .temp_i   (sel_temp),
        .fahr_i   (fahr),
        .counts_i (counts),
        .mv_i     (mv),
        .data_o   (fmt_data),
        .neg_o    (fmt_neg)
    );

    // ------------------------------------------------------------
    // Round-robin channel pointer
    // ------------------------------------------------------------
    assign wr_ctrl = wr_i && (addr_i == REG_CTRL);
    assign restart = wr_ctrl && wdata_i[CTRL_RST];
    assign advance = scan_evt && run;

    // A strap set shrunk below the pointer shows channel one next
    // skip inactive channels
    assign shown   = (cur > last_idx) ? 3'h0 : cur;

    // Wrap after the last active one; a shrunk strap set also wraps
    // count is code plus one
    assign next_cur = restart          ? 3'h0 :
                      !advance         ? cur :
                      (shown >= last_idx) ? 3'h0 : shown + 3'h1;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cur <= 3'h0;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Output word
    // ------------------------------------------------------------
    // Word only changes on a scan so the host never sees a tear
    // single word
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            word_o <= 16'h0000;
        end else if (advance) begin
            word_o <= {fmt_neg, shown, fmt_data};
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Run lets software freeze the word for inspection
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run <= RUN_DFLT;
        end else if (wr_ctrl) begin
            run <= wdata_i[CTRL_RUN];
        end
    end

    // Status: strap decode, current pointer, millivolt span
    assign stat_word = {8'h00, span_mv, 5'h00, cur,
                        2'h0, mv, counts, fahr, last_idx};

    // Unmapped addresses read zero
    assign rd_mux = (addr_i == REG_CTRL) ? {31'h0, run} :
                    (addr_i == REG_STAT) ? stat_word :
                    (addr_i == REG_WORD) ? {16'h0000, word_o} :
                    32'h0;

    // Read data stands for the cycle after the strobe only
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    // Pointer wraps to channel one after the last active channel
    a_chan_wrap : assert property (
        advance && !restart && shown >= last_idx |=> cur == 3'h0
    ) else $error("pointer did not wrap");

    // Pointer steps by one while below the last active channel
    a_chan_step : assert property (
        advance && !restart && cur < last_idx |=> cur == $past(cur) + 3'h1
    ) else $error("pointer did not step");

    // Pointer never passes the active group after a scan
    a_chan_range : assert property (
        advance && !restart |=> cur <= $past(last_idx)
    ) else $error("pointer left active group");

    // Identifier carries the channel shown at the scan
    a_word_id : assert property (
        advance |=> word_o[ID_MSB:ID_LSB] == $past(shown)
    ) else $error("identifier mismatch");

    // Data field carries the latest stored result
    a_word_data : assert property (
        advance |=> word_o[11:0] == $past(fmt_data)
    ) else $error("data field mismatch");

    // Sign bit tracks the formatted sign
    a_word_sign : assert property (
        advance |=> word_o[SIGN_B] == $past(fmt_neg)
    ) else $error("sign bit mismatch");

    // Word holds between scans
    a_word_hold : assert property (
        !advance |=> $stable(word_o)
    ) else $error("word changed without scan");

    // Counts format never exceeds 4094 and has no sign
    a_count_cap : assert property (
        counts |-> fmt_data <= COUNT_MAX_TC && !fmt_neg
    ) else $error("counts out of range");

    // Millivolt build passes the raw count unsigned
    a_mv_raw : assert property (
        mv |-> fmt_data == sel_cnt && !fmt_neg && !fahr && !counts
    ) else $error("millivolt not raw");

    // Restart returns to channel one
    a_restart : assert property (
        restart |=> cur == 3'h0
    ) else $error("restart ignored");

    // A read of the word register answers one cycle later with the word
    a_read_word : assert property (
        rd_i && addr_i == REG_WORD |=> rdata_o == {16'h0000, $past(word_o)}
    ) else $error("word read mismatch");

    // Two scans in a row with one active channel both show channel one
    a_single_ch : assert property (
        advance && last_idx == 3'h0 |=> word_o[ID_MSB:ID_LSB] == 3'h0
    ) else $error("single channel id wrong");

    // Converter pointer wraps to the first slot after the last active one
    a_conv_wrap : assert property (
        conv_vld_i && conv_ptr >= last_idx |=> conv_ptr == 3'h0
    ) else $error("converter pointer did not wrap");

    // Converter pointer steps by one inside the active group
    a_conv_step : assert property (
        conv_vld_i && conv_ptr < last_idx |=> conv_ptr == $past(conv_ptr) + 3'h1
    ) else $error("converter pointer did not step");

    // A finished conversion lands in its own slot
    a_slot_store : assert property (
        conv_vld_i |=> cnt_mem[$past(conv_ch_i)] == $past(conv_cnt_i)
    ) else $error("conversion not stored");

    // Straps read as the factory set until the pins pass the synchroniser
    a_default_strap : assert property (
        $fell(srst_i) |-> last_idx == 3'h7 && !fahr && !counts && !mv
    ) else $error("strap defaults wrong");

    // Celsius readings carry the sign of the stored reading
    a_celsius_sign : assert property (
        !mv && !counts && !fahr |-> fmt_neg == sel_temp[12]
    ) else $error("celsius sign wrong");

    // Positive Celsius readings pass through in whole degrees
    a_celsius_mag : assert property (
        !mv && !counts && !fahr && !sel_temp[12] |-> fmt_data == sel_temp[11:0]
    ) else $error("celsius magnitude wrong");

    // Fahrenheit goes negative only below minus eighteen Celsius
    a_fahr_sign : assert property (
        !mv && !counts && fahr |-> fmt_neg == (sel_temp < -13'sd18)
    ) else $error("fahrenheit sign wrong");

    // The word never names a channel outside the active group
    a_id_range : assert property (
        advance |=> word_o[ID_MSB:ID_LSB] <= $past(last_idx)
    ) else $error("identifier outside active group");

    // Counts below the cap pass through unchanged
    a_count_pass : assert property (
        counts && sel_cnt < COUNT_MAX_TC |-> fmt_data == sel_cnt
    ) else $error("counts altered");

    // The unit strap has no say while counts are selected
    a_unit_ignored : assert property (
        counts |-> !fahr
    ) else $error("unit strap not ignored");

endmodule : mtw_top

// *** design/mtw_pkg.sv ***
package mtw_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int NUM_CH  = 8;
    localparam int CH_W    = 3;
    localparam int DATA_W  = 12;
    localparam int WORD_W  = 16;
    localparam int ID_LSB  = 12;
    localparam int ID_MSB  = 14;
    localparam int SIGN_B  = 15;

    // ------------------------------------------------------------
    // Strap positions and factory defaults (1 = installed)
    // ------------------------------------------------------------
    localparam int STRAP_W    = 5;
    localparam int STRAP_UNIT = 3;
    localparam int STRAP_FMT  = 4;
    localparam logic [4:0] STRAP_DFLT = 5'h07;
    localparam logic       MV_DFLT    = 1'h0;
    localparam logic [1:0] SPAN_DFLT  = 2'h0;

    // ------------------------------------------------------------
    // Data limits and unit conversion
    // ------------------------------------------------------------
    localparam logic [11:0] COUNT_MAX_TC = 12'hffe;
    localparam logic [11:0] COUNT_MAX_MV = 12'hfff;
    localparam logic [11:0] MAG_MAX      = 12'hfff;
    localparam logic signed [17:0] F_MUL = 18'sh00009;
    localparam logic signed [17:0] F_DIV = 18'sh00005;
    localparam logic signed [17:0] F_OFS = 18'sh00020;

    // ------------------------------------------------------------
    // Millivolt spans, in mV, by span code
    // ------------------------------------------------------------
    localparam logic [1:0] SPAN_C50  = 2'h1;
    localparam logic [1:0] SPAN_C100 = 2'h2;
    localparam logic [1:0] SPAN_C25  = 2'h3;
    localparam logic [7:0] SPAN_50   = 8'h32;
    localparam logic [7:0] SPAN_100  = 8'h64;
    localparam logic [7:0] SPAN_25   = 8'h19;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL  = 4'h0;
    localparam logic [3:0]  REG_STAT  = 4'h4;
    localparam logic [3:0]  REG_WORD  = 4'h8;
    localparam int          CTRL_RUN  = 0;
    localparam int          CTRL_RST  = 1;
    localparam logic        RUN_DFLT  = 1'h1;

endpackage : mtw_pkg

// *** design/mtw_strap.sv ***
`timescale 1ns/10ps
module mtw_strap
    import mtw_pkg::*;
(
    input  wire logic         clk_i,        // Clock
    input  wire logic         srst_i,       // Sync reset
    input  wire logic [4:0]   strap_i,      // Jumper pins
    input  wire logic         mv_variant_i, // Millivolt build pin
    input  wire logic [1:0]   span_code_i,  // Millivolt span pin
    output logic      [2:0]   last_idx_o,   // Last active index
    output logic              fahr_o,       // Fahrenheit
    output logic              counts_o,     // Counts format
    output logic              mv_o,         // Millivolt build
    output logic      [7:0]   span_mv_o     // Span in mV
);

    logic [7:0] ff1;
    logic [7:0] ff2;

    // ------------------------------------------------------------
    // Two-stage synchroniser, resets to factory jumper set
    // ------------------------------------------------------------
    // factory default straps
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ff1 <= {SPAN_DFLT, MV_DFLT, STRAP_DFLT};
            ff2 <= {SPAN_DFLT, MV_DFLT, STRAP_DFLT};
        end else begin
            ff1 <= {span_code_i, mv_variant_i, strap_i};
            ff2 <= ff1;
        end
    end

    // Decode: millivolt builds have no unit or format jumper
    // binary count straps
    assign last_idx_o = ff2[2:0];
    assign mv_o       = ff2[5];
    assign counts_o   = ff2[STRAP_FMT] & ~ff2[5];
    assign fahr_o     = ff2[STRAP_UNIT] & ~counts_o & ~ff2[5];
    assign span_mv_o  = (ff2[7:6] == SPAN_C50)  ? SPAN_50  :
                        (ff2[7:6] == SPAN_C100) ? SPAN_100 :
                        (ff2[7:6] == SPAN_C25)  ? SPAN_25  : 8'h00;

endmodule : mtw_strap

// *** design/mtw_fmt.sv ***
`timescale 1ns/10ps
module mtw_fmt
    import mtw_pkg::*;
(
    input  wire logic        [11:0] count_i,  // Raw converter count
    input  wire logic signed [12:0] temp_i,   // Whole degrees C
    input  wire logic               fahr_i,   // Fahrenheit
    input  wire logic               counts_i, // Counts format
    input  wire logic               mv_i,     // Millivolt build
    output logic             [11:0] data_o,   // Data field
    output logic                    neg_o     // Sign bit
);

    logic signed [17:0] c_ext;
    logic signed [17:0] f_val;
    logic signed [17:0] t_sel;
    logic        [17:0] t_mag;

    // Celsius to Fahrenheit, whole degrees
    // degree resolution
    assign c_ext = 18'(temp_i);
    assign f_val = (c_ext * F_MUL) / F_DIV + F_OFS;
    assign t_sel = fahr_i ? f_val : c_ext;
    assign t_mag = t_sel[17] ? 18'(-t_sel) : 18'(t_sel);

    // Output mux; counts clamp keeps the 0..4094 range
    // counts range
    assign data_o = mv_i ? count_i :
                    counts_i ? ((count_i > COUNT_MAX_TC) ? COUNT_MAX_TC : count_i) :
                    ((t_mag > 18'(MAG_MAX)) ? MAG_MAX : t_mag[11:0]);
    assign neg_o  = ~mv_i & ~counts_i & t_sel[17];

endmodule : mtw_fmt

// *** bench/mtw_host_model.sv ***
`timescale 1ns/10ps
module mtw_host_model
    import mtw_pkg::*;
(
    input  wire logic        clk_i,  // Bench clock
    input  wire logic [15:0] word_i, // Input word from the block
    output logic             scan_o  // Scan pin to the block
);
    // ------------------------------------------------------------
    // Per-channel store, filled by the scan
    // ------------------------------------------------------------
    logic [11:0] chan_data [NUM_CH];

    initial begin
        scan_o = 1'h0;
        for (int i = 0; i < NUM_CH; i++) begin
            chan_data[i] = 12'h000;
        end
    end

    // One scan: pin held high and low long enough for the synchroniser
    task automatic do_scan(output logic [15:0] w);
        @(posedge clk_i);
        scan_o <= 1'h1;
        repeat (3) @(posedge clk_i);
        scan_o <= 1'h0;
        repeat (4) @(posedge clk_i);
        #1;
        w = word_i;
        chan_data[word_i[ID_MSB:ID_LSB]] = word_i[DATA_W-1:0];
    endtask : do_scan
endmodule : mtw_host_model

// *** bench/test_multiplexed_temp_input_word.sv ***
`timescale 1ns/10ps
module test_multiplexed_temp_input_word
    import mtw_pkg::*;
;
    typedef struct packed {
        logic [4:0]  strap;
        logic        mv;
        logic [11:0] cnt;
        logic [12:0] temp;
        logic [15:0] exp;
    } mtw_row_t;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic               clk_i        = 1'h0;
    logic               srst_i       = 1'h1;
    wire logic          scan_i;
    logic [4:0]         strap_i      = 5'h01;
    logic               mv_variant_i = 1'h0;
    logic [1:0]         span_code_i  = 2'h0;
    logic               conv_vld_i   = 1'h0;
    logic [2:0]         conv_ch_i    = 3'h0;
    logic [11:0]        conv_cnt_i   = 12'h000;
    logic signed [12:0] conv_temp_i  = 13'h0000;
    logic [3:0]         addr_i       = 4'h0;
    logic [31:0]        wdata_i      = 32'h0;
    logic               wr_i         = 1'h0;
    logic               rd_i         = 1'h0;
    logic [31:0]        rdata_o;
    logic [15:0]        word_o;
    logic [2:0]         conv_sel_o;
    int                 miscompares  = 0;
    int                 comparisons  = 0;
    int                 cycles       = 0;
    logic [31:0]        rd_val;
    logic [15:0]        w;
    logic [15:0]        w0;
    logic [7:0]         spans [4];
    mtw_row_t           rows [9];

    always #4 clk_i = ~clk_i;

    mtw_top u_mtw_top (.clk_i(clk_i), .srst_i(srst_i), .scan_i(scan_i), .strap_i(strap_i),
        .mv_variant_i(mv_variant_i), .span_code_i(span_code_i), .conv_vld_i(conv_vld_i),
        .conv_ch_i(conv_ch_i), .conv_cnt_i(conv_cnt_i), .conv_temp_i(conv_temp_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .word_o(word_o), .conv_sel_o(conv_sel_o));

    mtw_host_model u_mtw_host_model (.clk_i(clk_i), .word_i(word_o), .scan_o(scan_i));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask : chk

    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'h1;
        @(posedge clk_i);
        wr_i    <= 1'h0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'h1;
        @(posedge clk_i);
        rd_i   <= 1'h0;
        #1;
        rd_val = rdata_o;
    endtask : reg_rd

    task automatic conv(input logic [2:0] ch, input logic [11:0] c, input logic [12:0] t);
        @(posedge clk_i);
        conv_vld_i  <= 1'h1;
        conv_ch_i   <= ch;
        conv_cnt_i  <= c;
        conv_temp_i <= t;
        @(posedge clk_i);
        conv_vld_i  <= 1'h0;
        #1;
    endtask : conv

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        spans = '{8'h00, SPAN_50, SPAN_100, SPAN_25};
        rows = '{'{5'h07, 1'h0, 12'h000, 13'h0019, 16'h0019},
                 '{5'h0f, 1'h0, 12'h000, 13'h0064, 16'h00d4},
                 '{5'h0f, 1'h0, 12'h000, 13'h1fd8, 16'h8028},
                 '{5'h07, 1'h0, 12'h000, 13'h1ffb, 16'h8005},
                 '{5'h17, 1'h0, 12'hfff, 13'h1ffb, 16'h0ffe},
                 '{5'h1f, 1'h0, 12'h123, 13'h0064, 16'h0123},
                 '{5'h1f, 1'h1, 12'hfff, 13'h1fd8, 16'h0fff},
                 '{5'h0f, 1'h0, 12'h000, 13'h09c4, 16'h0fff},
                 '{5'h07, 1'h0, 12'h055, 13'h0000, 16'h0000}};
        repeat (2) @(posedge clk_i);
        srst_i <= 1'h0;
        @(posedge clk_i);
        #1;
        chk("word_o after reset", 32'h0, {16'h0, word_o});
        repeat (3) @(posedge clk_i);
        reg_rd(REG_CTRL);
        chk("ctrl reset", 32'h1, rd_val);
        reg_rd(REG_STAT);
        chk("stat two channels", 32'h1, rd_val);
        reg_rd(4'hc);
        chk("unmapped read", 32'h0, rd_val);
        reg_wr(4'hc, 32'hffffffff);
        reg_rd(REG_CTRL);
        chk("ctrl after unmapped write", 32'h1, rd_val);
        // Converter pointer walks two active channels only
        for (int i = 0; i < 4; i++) begin
            chk("conv_sel_o", 32'(i % 2), {29'h0, conv_sel_o});
            conv(conv_sel_o, 12'h000, 13'h0000);
        end
        // Ordinary cases: straps, build and reading against the word
        foreach (rows[r]) begin
            strap_i      <= rows[r].strap;
            mv_variant_i <= rows[r].mv;
            repeat (4) @(posedge clk_i);
            conv(3'h0, rows[r].cnt, rows[r].temp);
            reg_wr(REG_CTRL, 32'h3);
            u_mtw_host_model.do_scan(w);
            chk("word_o row", {16'h0, rows[r].exp}, {16'h0, w});
        end
        // Millivolt spans by code
        strap_i <= 5'h07;
        mv_variant_i <= 1'h1;
        for (int c = 1; c < 4; c++) begin
            span_code_i <= 2'(c);
            repeat (4) @(posedge clk_i);
            reg_rd(REG_STAT);
            chk("stat span", {8'h0, spans[c], 16'h0027}, rd_val & 32'h00ff0027);
        end
        mv_variant_i <= 1'h0;
        // Round robin with three and with eight active channels
        for (int s = 0; s < 2; s++) begin
            strap_i <= (s == 0) ? 5'h02 : 5'h07;
            repeat (4) @(posedge clk_i);
            for (int k = 0; k < NUM_CH; k++) begin
                conv(3'(k), 12'h000, 13'(10 * (k + 1)));
            end
            reg_wr(REG_CTRL, 32'h3);
            for (int i = 0; i < ((s == 0) ? 7 : 9); i++) begin
                u_mtw_host_model.do_scan(w);
                w0 = {1'h0, 3'(i % ((s == 0) ? 3 : 8)), 12'(10 * (i % ((s == 0) ? 3 : 8) + 1))};
                chk("word_o round robin", {16'h0, w0}, {16'h0, w});
            end
        end
        // Stopped scan leaves word and pointer alone
        reg_wr(REG_CTRL, 32'h0);
        w0 = word_o;
        u_mtw_host_model.do_scan(w);
        chk("word_o frozen", {16'h0, w0}, {16'h0, w});
        reg_rd(REG_STAT);
        chk("stat pointer", 32'h1, {29'h0, rd_val[10:8]});
        reg_wr(REG_CTRL, 32'h1);
        u_mtw_host_model.do_scan(w);
        chk("word_o resumed", 32'h1014, {16'h0, w});
        reg_rd(REG_WORD);
        chk("word register", 32'h1014, rd_val);
        @(posedge clk_i);
        #1;
        chk("rdata_o after read", 32'h0, rdata_o);
        chk("host routed ch8", 32'h50, {20'h0, u_mtw_host_model.chan_data[7]});
        // Shrink to one channel with the pointer on channel three
        strap_i <= 5'h00;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 2; i++) begin
            u_mtw_host_model.do_scan(w);
            chk("word_o single channel", 32'h000a, {16'h0, w});
        end
        // Second reset in mid-run
        srst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'h0;
        #1;
        chk("word_o second reset", 32'h0, {16'h0, word_o});
        chk("conv_sel_o second reset", 32'h0, {29'h0, conv_sel_o});
        stop_test();
    end
endmodule : test_multiplexed_temp_input_word
